// *** inc/tlvic_arb_if.sv ***
// tlvic_arb_if: carries eligible requests to the arbiter and its choice back.
// assumes both ends sit on the same clock; the arbiter is combinational.
`timescale 1ns/1ps
`default_nettype none
interface tlvic_arb_if;
  logic [20:0] elig;    // pending, enabled and globally enabled
  logic [20:0] prio;    // one means high level
  logic        ins_hi;  // high-level routine in service
  logic        ins_lo;  // low-level routine in service
  logic        hit;
  logic [4:0]  idx;
  logic        lvl;
  modport ctl (output elig, output prio, output ins_hi, output ins_lo,
               input hit, input idx, input lvl);
  modport arb (input elig, input prio, input ins_hi, input ins_lo,
               output hit, output idx, output lvl);
endinterface
`default_nettype wire

// *** inc/tlvic_pkg.sv ***
// tlvic_pkg: constants, register map and vector table of the interrupt controller.
// assumes a 32-bit AXI4-Lite register bus and a 100 MHz single clock.
`default_nettype none
package tlvic_pkg;
  // ==========================================================================
  // source set
  localparam int          NSRC        = 21;            // order numbers 0..20
  localparam logic [20:0] SRC_VALID   = 21'h1fdfff;    // order 13 has no source
  localparam logic [20:0] HW_CLR_MASK = 21'h08000f;    // cleared on vectoring
  localparam int          EXT_A_IDX   = 0;
  localparam int          EXT_B_IDX   = 2;
  // ==========================================================================
  // register byte addresses
  localparam logic [7:0] ADDR_TCTL  = 8'h00;  // timer_control_reg
  localparam logic [7:0] ADDR_GCTL  = 8'h04;  // global_irq_enable
  localparam logic [7:0] ADDR_ENA   = 8'h08;  // source_enable_regs
  localparam logic [7:0] ADDR_PRI   = 8'h0c;  // priority_select_regs
  localparam logic [7:0] ADDR_PSET  = 8'h10;  // pending, write one sets
  localparam logic [7:0] ADDR_PCLR  = 8'h14;  // pending, write one clears
  localparam logic [7:0] ADDR_STAT  = 8'h18;  // in-service and request state
  // ==========================================================================
  // field positions of timer_control_reg
  localparam int TCTL_A_TYPE = 0;
  localparam int TCTL_A_PEND = 1;
  localparam int TCTL_B_TYPE = 2;
  localparam int TCTL_B_PEND = 3;
  // field positions of the status register
  localparam int STAT_INS_LO = 0;
  localparam int STAT_INS_HI = 1;
  localparam int STAT_REQ    = 2;
  localparam int STAT_IDX    = 8;
  localparam int STAT_VEC    = 16;
  // ==========================================================================
  // reset values
  localparam logic [20:0] PRI_RESET = 21'h000000;  // all sources low level
  localparam logic [20:0] ENA_RESET = 21'h000000;
  localparam logic [1:0]  RESP_OK   = 2'b00;
  localparam logic [1:0]  RESP_ERR  = 2'b10;
  // ==========================================================================
  // timing: detection takes one clock before the request shows
  localparam int DETECT_NS  = 10;
  localparam int CLK_MHZ    = 100;
  localparam int DETECT_CYC = (DETECT_NS * CLK_MHZ + 999) / 1000;

  // code address of each source's service routine
  function automatic logic [15:0] tlvic_vector(input logic [4:0] idx);
    case (idx)
      5'd17:   tlvic_vector = 16'h0093;
      5'd18:   tlvic_vector = 16'h008b;
      default: tlvic_vector = 16'h0003 + {8'h00, idx, 3'b000};
    endcase
  endfunction
endpackage
`default_nettype wire

// *** src/tlvic_arb.sv ***
// tlvic_arb: two-level priority decode with fixed order inside a level.
// assumes elig already holds only valid, enabled, globally enabled sources.
`timescale 1ns/1ps
`default_nettype none
module tlvic_arb
  import tlvic_pkg::*;
(
  tlvic_arb_if.arb a
);
  // lowest order number wins inside a level
  function automatic logic [4:0] first_one(input logic [20:0] v);
    first_one = 5'd0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        first_one = i[4:0];
      end
    end
  endfunction

  // ==========================================================================
  // level split and preemption gate
  wire logic [20:0] hi_req = a.elig & a.prio;
  wire logic [20:0] lo_req = a.elig & ~a.prio;
  wire logic        hi_ok  = ~a.ins_hi;
  wire logic        lo_ok  = ~a.ins_hi & ~a.ins_lo;
  wire logic        hi_hit = hi_ok & (|hi_req);
  wire logic        lo_hit = lo_ok & (|lo_req);

  // high level first when both are recognised together
  assign a.hit = hi_hit | lo_hit;
  assign a.lvl = hi_hit;
  assign a.idx = hi_hit ? first_one(hi_req) : first_one(lo_req);
endmodule // tlvic_arb
`default_nettype wire

// *** src/tlvic_top.sv ***
// tlvic_top: vectored interrupt controller, two levels, 20 sources.
// assumes a core that pulses ack, return and instruction-done strobes,
// peripherals that pulse one set strobe per event, and an AXI4-Lite master.
`timescale 1ns/1ps
`default_nettype none
module tlvic_top
  import tlvic_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        reset,
  input  wire logic        clk_en,
  // external interrupt pins, active low
  input  wire logic        ext_irq_a_n,
  input  wire logic        ext_irq_b_n,
  // peripheral event strobes, one bit per order number
  input  wire logic [20:0] src_set,
  // core side
  input  wire logic        cpu_ack,
  input  wire logic        cpu_reti,
  input  wire logic        cpu_instr_done,
  output logic             irq_req,
  output logic [15:0]      irq_vector,
  output logic             irq_level,
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // byte-enable merge, used by every writable register but global_irq_enable and the timer type bits
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction

  // ==========================================================================
  // state
  logic [1:0]  ttype_r;            // one = edge triggered
  logic        gie_r;
  logic [20:0] ena_r;
  logic [20:0] pri_r;
  logic [20:0] pend_r;
  logic [20:0] pend_nxt;
  logic [1:0]  ins_r;              // bit1 high level, bit0 low level
  logic        wait_r;             // one instruction still owed after return
  logic        req_r;
  logic [15:0] vec_r;
  logic [4:0]  idx_r;
  logic        lvl_r;
  logic [1:0]  sy1_r;
  logic [1:0]  sy2_r;
  logic [1:0]  sy3_r;
  logic [1:0]  pin_r;              // filtered pin level, one = high
  logic        awready_r;
  logic        wready_r;
  logic        bvalid_r;
  logic [1:0]  bresp_r;
  logic        arready_r;
  logic        rvalid_r;
  logic [1:0]  rresp_r;
  logic [31:0] rdata_r;

  tlvic_arb_if arb_bus ();

  tlvic_arb u_arb (
    .a (arb_bus)
  );

  // ==========================================================================
  // bus decode: write taken only with address and data both present
  wire logic        wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_r
                              & ~awready_r;
  wire logic        rd_go   = s_axi_arvalid & ~rvalid_r & ~arready_r;
  wire logic [31:0] wmask   = strb_mask(s_axi_wstrb);
  wire logic [31:0] wbits   = s_axi_wdata & wmask;
  wire logic        wr_tctl = wr_go & (s_axi_awaddr == ADDR_TCTL);
  wire logic        wr_gctl = wr_go & (s_axi_awaddr == ADDR_GCTL);
  wire logic        wr_ena  = wr_go & (s_axi_awaddr == ADDR_ENA);
  wire logic        wr_pri  = wr_go & (s_axi_awaddr == ADDR_PRI);
  wire logic        wr_pset = wr_go & (s_axi_awaddr == ADDR_PSET);
  wire logic        wr_pclr = wr_go & (s_axi_awaddr == ADDR_PCLR);
  wire logic        wr_hit  = wr_tctl | wr_gctl | wr_ena | wr_pri
                              | wr_pset | wr_pclr;
  wire logic        rd_hit  = (s_axi_araddr == ADDR_TCTL) | (s_axi_araddr == ADDR_GCTL)
                              | (s_axi_araddr == ADDR_ENA) | (s_axi_araddr == ADDR_PRI)
                              | (s_axi_araddr == ADDR_PSET) | (s_axi_araddr == ADDR_PCLR)
                              | (s_axi_araddr == ADDR_STAT);

  // ==========================================================================
  // external pins: a level counts once the last two stages agree
  wire logic [1:0] agree   = ~(sy2_r ^ sy3_r);     // per pin, so one pin never stalls the other
  wire logic [1:0] pin_nxt = (sy3_r & agree) | (pin_r & ~agree);
  wire logic [1:0] fall    = pin_r & ~pin_nxt;

  // ==========================================================================
  // software set and clear of pending flags
  wire logic [20:0] tctl_pset = {18'h00000, wbits[TCTL_B_PEND], 1'b0,
                                 wbits[TCTL_A_PEND]};
  wire logic [20:0] tctl_pclr = {18'h00000, wmask[TCTL_B_PEND] & ~s_axi_wdata[TCTL_B_PEND],
                                 1'b0, wmask[TCTL_A_PEND] & ~s_axi_wdata[TCTL_A_PEND]};
  wire logic [20:0] sw_set = ({21{wr_pset}} & wbits[20:0])
                             | ({21{wr_tctl}} & tctl_pset);
  wire logic [20:0] sw_clr = ({21{wr_pclr}} & wbits[20:0])
                             | ({21{wr_tctl}} & tctl_pclr);
  wire logic [20:0] edge_ev = {18'h00000, fall[1] & ttype_r[1], 1'b0,
                               fall[0] & ttype_r[0]};
  wire logic [20:0] ext_m   = {18'h00000, 1'b1, 1'b0, 1'b1};
  wire logic [20:0] hw_set  = (src_set & ~ext_m) | edge_ev;

  // ==========================================================================
  // core handshake
  wire logic        take    = cpu_ack & req_r;
  wire logic [20:0] idx_oh  = 21'h000001 << idx_r;
  wire logic [20:0] lvl_ext = {18'h00000, ~ttype_r[1], 1'b0, ~ttype_r[0]};
  wire logic [20:0] vec_clr = {21{take}} & idx_oh & HW_CLR_MASK & ~lvl_ext;
  wire logic [20:0] mirror  = {18'h00000, ~pin_nxt[1], 1'b0, ~pin_nxt[0]};

  // pending update: a set in the same cycle as a clear wins
  always_comb begin
    pend_nxt = ((pend_r & ~(sw_clr | vec_clr)) | sw_set | hw_set) & SRC_VALID;
    pend_nxt = (pend_nxt & ~lvl_ext) | (mirror & lvl_ext);
  end

  // ==========================================================================
  // arbiter inputs
  assign arb_bus.elig   = pend_r & ena_r & {21{gie_r}} & SRC_VALID;
  assign arb_bus.prio   = pri_r;
  assign arb_bus.ins_hi = ins_r[1];
  assign arb_bus.ins_lo = ins_r[0];

  // request withheld while taken, in the return cycle and while an instruction is owed
  wire logic       req_nxt = arb_bus.hit & ~wait_r & ~take & ~cpu_reti;
  // return clears the highest active marker
  wire logic [1:0] ins_ret = ins_r[1] ? {1'b0, ins_r[0]} : 2'b00;
  wire logic [1:0] ins_set = take ? (lvl_r ? 2'b10 : 2'b01) : 2'b00;
  wire logic [1:0] ins_nxt = (cpu_reti ? ins_ret : ins_r) | ins_set;

  // ==========================================================================
  // pin synchroniser, three stages
  always_ff @(posedge clock) begin
    if (reset) begin
      sy1_r <= 2'b11;
      sy2_r <= 2'b11;
      sy3_r <= 2'b11;
      pin_r <= 2'b11;
    end else if (clk_en) begin
      sy1_r <= {ext_irq_b_n, ext_irq_a_n};
      sy2_r <= sy1_r;
      sy3_r <= sy2_r;
      pin_r <= pin_nxt;
    end
  end

  // ==========================================================================
  // configuration registers, written by software
  always_ff @(posedge clock) begin
    if (reset) begin
      ttype_r <= 2'b00;
      gie_r   <= 1'b0;
      ena_r   <= ENA_RESET;
      pri_r   <= PRI_RESET;
    end else if (clk_en) begin
      if (wr_tctl && s_axi_wstrb[0]) begin
        ttype_r <= {s_axi_wdata[TCTL_B_TYPE], s_axi_wdata[TCTL_A_TYPE]};
      end
      if (wr_gctl && s_axi_wstrb[0]) begin
        gie_r <= s_axi_wdata[0];
      end
      if (wr_ena) begin
        ena_r <= ((ena_r & ~wmask[20:0]) | wbits[20:0]) & SRC_VALID;
      end
      if (wr_pri) begin
        pri_r <= ((pri_r & ~wmask[20:0]) | wbits[20:0]) & SRC_VALID;
      end
    end
  end

  // ==========================================================================
  // pending flags and in-service markers, evaluated on every clock with clk_en high
  always_ff @(posedge clock) begin
    if (reset) begin
      pend_r <= 21'h000000;
      ins_r  <= 2'b00;
      wait_r <= 1'b0;
    end else if (clk_en) begin
      pend_r <= pend_nxt;
      ins_r  <= ins_nxt;
      if (cpu_reti) begin
        wait_r <= 1'b1;
      end else if (cpu_instr_done) begin
        wait_r <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // request to the core: one clock of detection, then the core's long call
  always_ff @(posedge clock) begin
    if (reset) begin
      req_r <= 1'b0;
      vec_r <= 16'h0000;
      idx_r <= 5'h00;
      lvl_r <= 1'b0;
    end else if (clk_en) begin
      req_r <= req_nxt;
      if (arb_bus.hit) begin
        idx_r <= arb_bus.idx;
        lvl_r <= arb_bus.lvl;
        vec_r <= tlvic_vector(arb_bus.idx);
      end
    end
  end

  // ==========================================================================
  // write channel: one cycle ready pulse, response held until bready
  always_ff @(posedge clock) begin
    if (reset) begin
      awready_r <= 1'b0;
      wready_r  <= 1'b0;
      bvalid_r  <= 1'b0;
      bresp_r   <= RESP_OK;
    end else if (clk_en) begin
      awready_r <= wr_go;
      wready_r  <= wr_go;
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= wr_hit ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // status word: markers, live request, chosen source and its vector
  wire logic [31:0] stat_w = {vec_r, 3'b000, idx_r, 5'b00000, req_r, ins_r};
  wire logic [31:0] tctl_w = {28'h0000000, pend_r[EXT_B_IDX], ttype_r[1],
                              pend_r[EXT_A_IDX], ttype_r[0]};
  logic [31:0] rd_mux;
  always_comb begin
    case (s_axi_araddr)
      ADDR_TCTL: rd_mux = tctl_w;
      ADDR_GCTL: rd_mux = {31'h00000000, gie_r};
      ADDR_ENA:  rd_mux = {11'h000, ena_r};
      ADDR_PRI:  rd_mux = {11'h000, pri_r};
      ADDR_PSET: rd_mux = {11'h000, pend_r};
      ADDR_PCLR: rd_mux = {11'h000, pend_r};
      ADDR_STAT: rd_mux = stat_w;
      default:   rd_mux = 32'h00000000;
    endcase
  end

  // ==========================================================================
  // read channel: data held until rready
  always_ff @(posedge clock) begin
    if (reset) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rresp_r   <= RESP_OK;
      rdata_r   <= 32'h00000000;
    end else if (clk_en) begin
      arready_r <= rd_go;
      if (rd_go) begin
        rvalid_r <= 1'b1;
        rresp_r  <= rd_hit ? RESP_OK : RESP_ERR;
        rdata_r  <= rd_mux;
      end else if (s_axi_rready) begin
        rvalid_r <= 1'b0;
      end
    end
  end

  // outputs straight from flops
  assign irq_req       = req_r;
  assign irq_vector    = vec_r;
  assign irq_level     = lvl_r;
  assign s_axi_awready = awready_r;
  assign s_axi_wready  = wready_r;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;
endmodule // tlvic_top
`default_nettype wire

// *** test/tb_top.sv ***
// tb_top: self-checking bench of the interrupt controller.
// assumes the core model beside the design and a task-based bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import tlvic_pkg::*;
;
  logic        clock, reset, pin_a_n, pin_b_n, ack, reti, done, req, lvl, en;
  logic [20:0] src_set;
  logic [15:0] vec;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp;
  int          n_errors = 0;
  int          num_checks = 0;
  // ==========================================================================
  // design and core
  tlvic_top i_dut (.clock(clock), .reset(reset), .clk_en(en),
    .ext_irq_a_n(pin_a_n), .ext_irq_b_n(pin_b_n), .src_set(src_set),
    .cpu_ack(ack), .cpu_reti(reti), .cpu_instr_done(done), .irq_req(req),
    .irq_vector(vec), .irq_level(lvl), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  tlvic_core_model u_core (.clock(clock), .irq_req(req), .irq_vector(vec),
    .irq_level(lvl), .cpu_ack(ack), .cpu_reti(reti), .cpu_instr_done(done));
  // ==========================================================================
  // helpers
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  task automatic chk(input logic ok, input string m);
    num_checks++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  // both write channels offered together, bready held until bvalid seen
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic got;
    got = 1'b0;
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!got) begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) begin
        got = 1'b1;
        bready <= 1'b0;
        chk(bresp === RESP_OK, "write response");
      end
    end
  endtask
  task automatic axr(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er,
                     input string m);
    logic got;
    got = 1'b0;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!got) begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        got = 1'b1;
        rready <= 1'b0;
        chk(rdata === e && rresp === er, m);
      end
    end
  endtask
  // wait for the core to take a request and compare level and vector
  task automatic take(input logic [16:0] e, input string m);
    int i;
    i = 0;
    while (u_core.taken.size() == 0 && i < 80) begin
      @(posedge clock);
      #1;
      i++;
    end
    chk(u_core.taken.size() > 0 && u_core.taken[0] === e, m);
    if (u_core.taken.size() > 0) void'(u_core.taken.pop_front());
  endtask
  task automatic idle(input string m);
    repeat (20) @(posedge clock);
    chk(u_core.taken.size() == 0, m);
  endtask
  function automatic logic [15:0] vec_of(input int k);
    if (k == 17) return 16'h0093;
    if (k == 18) return 16'h008b;
    return 16'(k * 8 + 3);
  endfunction
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    repeat (30000) @(posedge clock);
    n_errors++;
    complete_run();
  end
  // ==========================================================================
  // tests
  initial begin
    {reset, pin_a_n, pin_b_n, en} = 4'hf;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {src_set, awaddr, araddr, wdata} = '0;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    axr(ADDR_PRI, 32'h0, RESP_OK, "priority reset");
    axr(ADDR_ENA, 32'h0, RESP_OK, "enable reset");
    axr(ADDR_TCTL, 32'h0, RESP_OK, "tctl reset");
    axr(8'h1c, 32'h0, RESP_ERR, "unmapped read");
    // flag sets with global enable off, request only once it is on
    u_core.slow = 3;
    axw(ADDR_ENA, 32'h001fdfff);
    axw(ADDR_PSET, 32'h2);
    axr(ADDR_PSET, 32'h2, RESP_OK, "flag without enable");
    idle("request with global off");
    axw(ADDR_GCTL, 32'h1);
    take({1'b0, 16'h000b}, "software set vector");
    axr(ADDR_PSET, 32'h0, RESP_OK, "hardware clear");
    u_core.ret();
    u_core.slow = 0;
    // every strobed source: two-clock request, own vector
    for (int k = 1; k < 21; k++) begin
      if (k == 2 || k == 13) continue;
      @(posedge clock);
      src_set <= 21'(1) << k;
      @(posedge clock);
      src_set <= '0;
      @(posedge clock);
      #1;
      chk(req === 1'b1, "strobe latency");
      take({1'b0, vec_of(k)}, "source vector");
      axw(ADDR_PCLR, 32'(1) << k);
      u_core.ret();
    end
    // flag left set is taken again after return
    axw(ADDR_PSET, 32'h10);
    take({1'b0, 16'h0023}, "first entry");
    u_core.ret();
    take({1'b0, 16'h0023}, "re-entry");
    axw(ADDR_PCLR, 32'h10);
    u_core.ret();
    idle("no re-entry after clear");
    // two levels, nesting and fixed order
    axw(ADDR_PRI, 32'ha0);
    axw(ADDR_PSET, 32'h170);
    take({1'b1, 16'h002b}, "high first");
    idle("high routine blocks");
    axw(ADDR_PCLR, 32'h20);
    u_core.ret();
    take({1'b0, 16'h0023}, "lowest order");
    axw(ADDR_PCLR, 32'h10);
    axw(ADDR_PSET, 32'h80);
    take({1'b1, 16'h003b}, "preempt low");
    axw(ADDR_PCLR, 32'h80);
    u_core.ret();
    idle("equal level waits");
    u_core.ret();
    take({1'b0, 16'h0033}, "next low");
    axw(ADDR_PCLR, 32'h40);
    u_core.ret();
    take({1'b0, 16'h0043}, "last low");
    axw(ADDR_PCLR, 32'h100);
    u_core.ret();
    // external pins: a edge-triggered, b level-triggered
    axw(ADDR_TCTL, 32'h1);
    pin_a_n <= 1'b0;
    take({1'b0, 16'h0003}, "pin a vector");
    axr(ADDR_TCTL, 32'h1, RESP_OK, "edge flag cleared");
    pin_a_n <= 1'b1;
    u_core.ret();
    pin_b_n <= 1'b0;
    take({1'b0, 16'h0013}, "pin b vector");
    axr(ADDR_TCTL, 32'h9, RESP_OK, "level flag follows");
    pin_b_n <= 1'b1;
    repeat (8) @(posedge clock);
    axr(ADDR_TCTL, 32'h1, RESP_OK, "level flag released");
    u_core.ret();
    idle("released pin quiet");
    // enable low freezes every flop; the held strobe lands once it runs
    en <= 1'b0;
    src_set <= 21'h000200;
    idle("frozen while disabled");
    en <= 1'b1;
    @(posedge clock);
    src_set <= '0;
    take({1'b0, 16'h004b}, "resumes after enable");
    axw(ADDR_PCLR, 32'h200);
    u_core.ret();
    complete_run();
  end
endmodule // tb_top
`default_nettype wire

// *** test/tlvic_core_model.sv ***
// tlvic_core_model: behavioural cpu core facing the controller.
// assumes the request/ack handshake; the bench ends routines with ret().
`timescale 1ns/1ps
`default_nettype none
module tlvic_core_model (
  input  wire logic        clock,
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  input  wire logic        irq_level,
  output logic             cpu_ack,
  output logic             cpu_reti,
  output logic             cpu_instr_done
);
  int          slow = 0;  // cycles the request stands before the core takes it
  int          wait_n = 0;
  logic [16:0] taken[$];
  initial begin
    cpu_ack = 1'b0;
    cpu_reti = 1'b0;
    cpu_instr_done = 1'b0;
  end
  // vector is logged at the edge where the controller sees the ack
  always @(posedge clock) begin
    if (cpu_ack && irq_req) taken.push_back({irq_level, irq_vector});
    if (irq_req && !cpu_ack && wait_n >= slow) begin
      cpu_ack <= 1'b1;
      wait_n = 0;
    end else begin
      cpu_ack <= 1'b0;
      if (irq_req && !cpu_ack) wait_n++;
    end
  end
  // return, then exactly one instruction before the next call
  task automatic ret();
    @(posedge clock);
    cpu_reti <= 1'b1;
    @(posedge clock);
    cpu_reti <= 1'b0;
    cpu_instr_done <= 1'b1;
    @(posedge clock);
    cpu_instr_done <= 1'b0;
  endtask
endmodule // tlvic_core_model
`default_nettype wire

// *** test/tlvic_monitor.sv ***
// tlvic_monitor: port-level checks of the interrupt controller.
// assumes it is bound to tlvic_top; one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module tlvic_monitor (
  input wire logic        clock,
  input wire logic        reset,
  input wire logic        clk_en,
  input wire logic        cpu_ack,
  input wire logic        cpu_reti,
  input wire logic        cpu_instr_done,
  input wire logic        irq_req,
  input wire logic [15:0] irq_vector,
  input wire logic        irq_level,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ==========================================================================
  // in-service markers rebuilt from the core handshake
  logic hi_r;
  logic lo_r;
  always_ff @(posedge clock) begin
    if (reset) begin
      hi_r <= 1'b0;
      lo_r <= 1'b0;
    end else if (clk_en && irq_req && cpu_ack) begin
      hi_r <= hi_r | irq_level;
      lo_r <= lo_r | ~irq_level;
    end else if (clk_en && cpu_reti) begin
      hi_r <= 1'b0;
      lo_r <= lo_r & hi_r;  // return closes the high routine first
    end
  end
  // ==========================================================================
  // core side
  AST_ACK_DROP: assert property (clk_en && irq_req && cpu_ack |=> !irq_req)
    else $error("request held after ack");
  AST_RETI_WAIT: assert property (clk_en && cpu_reti && !cpu_instr_done |=> !irq_req)
    else $error("request before owed instruction");
  AST_VEC_FORM: assert property (irq_req |-> irq_vector[2:0] == 3'b011)
    else $error("vector off its eight-byte slot");
  AST_HI_BLOCKS: assert property (hi_r |-> !irq_req)
    else $error("request during high routine");
  AST_LO_ONLY_HI: assert property (lo_r && irq_req |-> irq_level)
    else $error("low request during low routine");
  // ==========================================================================
  // register bus
  AST_AW_TAKE: assert property (clk_en && s_axi_awvalid && s_axi_wvalid && !s_axi_awready
      && !s_axi_bvalid |=> s_axi_awready && s_axi_wready && s_axi_bvalid)
    else $error("write not answered in one cycle");
  AST_AR_TAKE: assert property (clk_en && s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
      |=> s_axi_arready && s_axi_rvalid)
    else $error("read not answered in one cycle");
  AST_R_DROP: assert property (clk_en && s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after taken");
endmodule // tlvic_monitor
bind tlvic_top tlvic_monitor u_mon (.clock(clock), .reset(reset), .clk_en(clk_en),
  .cpu_ack(cpu_ack), .cpu_reti(cpu_reti), .cpu_instr_done(cpu_instr_done),
  .irq_req(irq_req), .irq_vector(irq_vector), .irq_level(irq_level),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready));
`default_nettype wire
